// ==== core/hsq_pkg.sv ====
// constants, step encodings and state type of the homing switch sequencer
package hsq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // homing method numbers
  localparam int             METHOD_W  = 6;
  localparam logic [5:0]     METHOD_19 = 6'h13;
  localparam logic [5:0]     METHOD_20 = 6'h14;
  localparam logic [5:0]     METHOD_21 = 6'h15;
  localparam logic [5:0]     METHOD_22 = 6'h16;
  localparam logic [5:0]     METHOD_23 = 6'h17;
  localparam logic [5:0]     METHOD_24 = 6'h18;

  ////////////////////////////////////////////////////////////////////////////
  // step word: direction, speed, awaited switch edge, action on that edge
  localparam int             STEP_W        = 6;
  localparam int             STEP_DIR_BIT  = 5;
  localparam int             STEP_FAST_BIT = 4;
  localparam int             STEP_EV_LSB   = 2;
  localparam int             STEP_ACT_LSB  = 0;
  localparam logic           DIR_FWD       = 1'b1;
  localparam logic           DIR_REV       = 1'b0;
  localparam logic           SPD_FAST      = 1'b1;
  localparam logic           SPD_SLOW      = 1'b0;
  localparam logic [1:0]     EV_RISE       = 2'h0;  // switch off to on
  localparam logic [1:0]     EV_FALL       = 2'h1;  // switch on to off
  localparam logic [1:0]     ACT_STOP      = 2'h0;  // decelerate, then next step
  localparam logic [1:0]     ACT_SLOW      = 2'h1;  // drop to low speed, keep going
  localparam logic [1:0]     ACT_HOME      = 2'h2;  // decelerate, latch home

  ////////////////////////////////////////////////////////////////////////////
  // step table entry points
  localparam int             IDX_W         = 5;
  localparam logic [4:0]     IDX_A_COLD    = 5'h00;  // 19 and 23 cold
  localparam logic [4:0]     IDX_A_WARM    = 5'h01;  // 19 and 23 warm
  localparam logic [4:0]     IDX_B_COLD    = 5'h02;  // 20 and 24 cold
  localparam logic [4:0]     IDX_B_WARM    = 5'h03;  // 20 and 24 warm
  localparam logic [4:0]     IDX_C_COLD    = 5'h05;  // 21 cold
  localparam logic [4:0]     IDX_C_WARM    = 5'h06;  // 21 warm
  localparam logic [4:0]     IDX_D_COLD    = 5'h07;  // 22 cold
  localparam logic [4:0]     IDX_D_WARM    = 5'h08;  // 22 warm
  localparam logic [4:0]     IDX_E_TURN    = 5'h0A;  // 23 after limit turnaround
  localparam logic [4:0]     IDX_F_TURN    = 5'h0E;  // 24 after limit turnaround
  localparam logic [4:0]     IDX_ONE       = 5'h01;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states, gray along idle-settle-move-done
  typedef enum logic [2:0] {
    HSQ_IDLE   = 3'h0,
    HSQ_SETTLE = 3'h1,
    HSQ_MOVE   = 3'h3,
    HSQ_DONE   = 3'h2,
    HSQ_ALARM  = 3'h6
  } hsq_state_t;

  localparam logic [1:0]     RST_SYNC_INIT = 2'h0;

endpackage

// ==== core/hsq_edge_detect.sv ====
// edge detector for the home and forward limit switch inputs
module hsq_edge_detect #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] sig_in,
  output wire logic [WIDTH-1:0] rise,
  output wire logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // previous sample; clears to inactive, so a switch already on at reset
  // shows one false rise that the sequencer never sees outside motion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= sig_in;
    end
  end

  // one-cycle edge pulses
  assign rise = sig_in & ~prev_reg;
  assign fall = ~sig_in & prev_reg;

endmodule // hsq_edge_detect

// ==== core/hsq_homing_sequencer.sv ====
// homing switch sequencer for methods 19 to 24
module hsq_homing_sequencer #(
  parameter int SPEED_W = 16,
  parameter int POS_W   = 32
) (
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic                         start,
  input  wire logic [hsq_pkg::METHOD_W-1:0] method,
  input  wire logic [SPEED_W-1:0]           high_speed,
  input  wire logic [SPEED_W-1:0]           low_speed,
  input  wire logic                         home_switch,
  input  wire logic                         forward_limit_switch,
  input  wire logic                         reverse_limit_switch,
  input  wire logic                         motion_standstill,
  input  wire logic [POS_W-1:0]             current_position,
  output logic                              motion_run,
  output logic                              motion_forward,
  output logic [SPEED_W-1:0]                motion_speed,
  output logic                              homing_busy,
  output logic                              homing_done,
  output logic                              homing_alarm,
  output logic [POS_W-1:0]                  home_position
);

  ////////////////////////////////////////////////////////////////////////////
  // step table; each chain runs forward from its entry point
  function automatic logic [hsq_pkg::STEP_W-1:0] step_of(input logic [hsq_pkg::IDX_W-1:0] idx);
    case (idx)
      5'h00:   step_of = {hsq_pkg::DIR_FWD, hsq_pkg::SPD_FAST, hsq_pkg::EV_RISE, hsq_pkg::ACT_STOP};
      5'h01:   step_of = {hsq_pkg::DIR_REV, hsq_pkg::SPD_SLOW, hsq_pkg::EV_FALL, hsq_pkg::ACT_HOME};
      5'h02:   step_of = {hsq_pkg::DIR_FWD, hsq_pkg::SPD_FAST, hsq_pkg::EV_RISE, hsq_pkg::ACT_STOP};
      5'h03:   step_of = {hsq_pkg::DIR_REV, hsq_pkg::SPD_SLOW, hsq_pkg::EV_FALL, hsq_pkg::ACT_STOP};
      5'h04:   step_of = {hsq_pkg::DIR_FWD, hsq_pkg::SPD_SLOW, hsq_pkg::EV_RISE, hsq_pkg::ACT_HOME};
      5'h05:   step_of = {hsq_pkg::DIR_REV, hsq_pkg::SPD_FAST, hsq_pkg::EV_RISE, hsq_pkg::ACT_STOP};
      5'h06:   step_of = {hsq_pkg::DIR_FWD, hsq_pkg::SPD_SLOW, hsq_pkg::EV_FALL, hsq_pkg::ACT_HOME};
      5'h07:   step_of = {hsq_pkg::DIR_REV, hsq_pkg::SPD_FAST, hsq_pkg::EV_RISE, hsq_pkg::ACT_STOP};
      5'h08:   step_of = {hsq_pkg::DIR_FWD, hsq_pkg::SPD_SLOW, hsq_pkg::EV_FALL, hsq_pkg::ACT_STOP};
      5'h09:   step_of = {hsq_pkg::DIR_REV, hsq_pkg::SPD_SLOW, hsq_pkg::EV_RISE, hsq_pkg::ACT_HOME};
      5'h0A:   step_of = {hsq_pkg::DIR_REV, hsq_pkg::SPD_FAST, hsq_pkg::EV_RISE, hsq_pkg::ACT_SLOW};
      5'h0B:   step_of = {hsq_pkg::DIR_REV, hsq_pkg::SPD_SLOW, hsq_pkg::EV_FALL, hsq_pkg::ACT_STOP};
      5'h0C:   step_of = {hsq_pkg::DIR_FWD, hsq_pkg::SPD_SLOW, hsq_pkg::EV_RISE, hsq_pkg::ACT_STOP};
      5'h0D:   step_of = {hsq_pkg::DIR_REV, hsq_pkg::SPD_SLOW, hsq_pkg::EV_FALL, hsq_pkg::ACT_HOME};
      5'h0E:   step_of = {hsq_pkg::DIR_REV, hsq_pkg::SPD_FAST, hsq_pkg::EV_RISE, hsq_pkg::ACT_SLOW};
      5'h0F:   step_of = {hsq_pkg::DIR_REV, hsq_pkg::SPD_SLOW, hsq_pkg::EV_FALL, hsq_pkg::ACT_STOP};
      5'h10:   step_of = {hsq_pkg::DIR_FWD, hsq_pkg::SPD_SLOW, hsq_pkg::EV_RISE, hsq_pkg::ACT_HOME};
      default: step_of = {hsq_pkg::DIR_REV, hsq_pkg::SPD_SLOW, hsq_pkg::EV_FALL, hsq_pkg::ACT_HOME};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [1:0]                    rst_sync_reg;
  logic                          rst_n;
  hsq_pkg::hsq_state_t           state_reg,    state_next;
  logic [hsq_pkg::IDX_W-1:0]     step_reg,     step_next;
  logic                          turn_used_reg, turn_used_next;
  logic                          finish_reg,   finish_next;
  logic                          run_reg,      run_next;
  logic                          fwd_reg,      fwd_next;
  logic [SPEED_W-1:0]            speed_reg,    speed_next;
  logic                          done_reg,     done_next;
  logic                          alarm_reg,    alarm_next;
  logic [POS_W-1:0]              home_pos_reg, home_pos_next;
  logic [1:0]                    sw_rise;
  logic [1:0]                    sw_fall;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= hsq_pkg::RST_SYNC_INIT;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // switch edges: bit 0 home switch, bit 1 forward limit
  hsq_edge_detect #(
    .WIDTH (2)
  ) u_edges (
    .clk    (clk),
    .rst_n  (rst_n),
    .sig_in ({forward_limit_switch, home_switch}),
    .rise   (sw_rise),
    .fall   (sw_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode of the current and following step
  wire [hsq_pkg::IDX_W-1:0]  step_plus  = step_reg + hsq_pkg::IDX_ONE;
  wire [hsq_pkg::STEP_W-1:0] cur_word   = step_of(step_reg);
  wire [hsq_pkg::STEP_W-1:0] plus_word  = step_of(step_plus);
  wire                       cur_fwd    = cur_word[hsq_pkg::STEP_DIR_BIT];
  wire                       cur_fast   = cur_word[hsq_pkg::STEP_FAST_BIT];
  wire [1:0]                 cur_ev     = cur_word[hsq_pkg::STEP_EV_LSB +: 2];
  wire [1:0]                 cur_act    = cur_word[hsq_pkg::STEP_ACT_LSB +: 2];
  wire                       plus_fast  = plus_word[hsq_pkg::STEP_FAST_BIT];
  wire [SPEED_W-1:0]         cur_speed  = cur_fast ? high_speed : low_speed;
  wire [SPEED_W-1:0]         plus_speed = plus_fast ? high_speed : low_speed;

  // awaited home switch edge of the running step
  wire ev_hit = (cur_ev == hsq_pkg::EV_RISE) ? sw_rise[0] : sw_fall[0];

  ////////////////////////////////////////////////////////////////////////////
  // method decode and entry point from the switch level at start
  wire m19     = (method == hsq_pkg::METHOD_19);
  wire m20     = (method == hsq_pkg::METHOD_20);
  wire m21     = (method == hsq_pkg::METHOD_21);
  wire m22     = (method == hsq_pkg::METHOD_22);
  wire m23     = (method == hsq_pkg::METHOD_23);
  wire m24     = (method == hsq_pkg::METHOD_24);
  wire turn_md = m23 | m24;
  wire valid_md = m19 | m20 | m21 | m22 | m23 | m24;

  // warm start picks the reverse or forward slow chain entry
  wire [hsq_pkg::IDX_W-1:0] entry_idx =
      (m19 | m23) ? (home_switch ? hsq_pkg::IDX_A_WARM : hsq_pkg::IDX_A_COLD) :
      (m20 | m24) ? (home_switch ? hsq_pkg::IDX_B_WARM : hsq_pkg::IDX_B_COLD) :
      m21         ? (home_switch ? hsq_pkg::IDX_C_WARM : hsq_pkg::IDX_C_COLD) :
                    (home_switch ? hsq_pkg::IDX_D_WARM : hsq_pkg::IDX_D_COLD);

  // chain taken after the one permitted forward limit turnaround
  wire [hsq_pkg::IDX_W-1:0] turn_idx = m23 ? hsq_pkg::IDX_E_TURN : hsq_pkg::IDX_F_TURN;

  ////////////////////////////////////////////////////////////////////////////
  // limit supervision; level for 19-22, second forward hit by edge for 23/24
  wire abort_plain = ~turn_md & (forward_limit_switch | reverse_limit_switch);
  wire abort_turn  = turn_md & (reverse_limit_switch | (turn_used_reg & sw_rise[1]));
  wire limit_abort = abort_plain | abort_turn;
  wire turn_hit    = turn_md & ~turn_used_reg & forward_limit_switch & cur_fwd;
  wire start_ok    = start & valid_md;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state; method and speeds are read live throughout
  always_comb begin
    state_next     = state_reg;
    step_next      = step_reg;
    turn_used_next = turn_used_reg;
    finish_next    = finish_reg;
    run_next       = run_reg;
    fwd_next       = fwd_reg;
    speed_next     = speed_reg;
    done_next      = done_reg;
    alarm_next     = alarm_reg;
    home_pos_next  = home_pos_reg;
    case (state_reg)
      hsq_pkg::HSQ_IDLE, hsq_pkg::HSQ_DONE, hsq_pkg::HSQ_ALARM: begin
        // a new start clears done and alarm but keeps home_position; a bad method alarms at once
        if (start) begin
          done_next      = 1'b0;
          turn_used_next = 1'b0;
          finish_next    = 1'b0;
          step_next      = entry_idx;
          alarm_next     = ~valid_md;
          state_next     = start_ok ? hsq_pkg::HSQ_SETTLE : hsq_pkg::HSQ_ALARM;
        end
      end
      hsq_pkg::HSQ_SETTLE: begin
        // wait for standstill, then launch the step or finish homing
        if (limit_abort) begin
          alarm_next = 1'b1;
          state_next = hsq_pkg::HSQ_ALARM;
        end else if (motion_standstill) begin
          if (finish_reg) begin
            home_pos_next = current_position;
            done_next     = 1'b1;
            state_next    = hsq_pkg::HSQ_DONE;
          end else begin
            run_next   = 1'b1;
            fwd_next   = cur_fwd;
            speed_next = cur_speed;
            state_next = hsq_pkg::HSQ_MOVE;
          end
        end
      end
      hsq_pkg::HSQ_MOVE: begin
        if (limit_abort) begin
          // run demand drops with the alarm; done stays clear
          run_next   = 1'b0;
          alarm_next = 1'b1;
          state_next = hsq_pkg::HSQ_ALARM;
        end else if (turn_hit) begin
          run_next       = 1'b0;
          turn_used_next = 1'b1;
          step_next      = turn_idx;
          state_next     = hsq_pkg::HSQ_SETTLE;
        end else if (ev_hit) begin
          case (cur_act)
            hsq_pkg::ACT_SLOW: begin
              // decelerate on the fly, same direction, no stop
              step_next  = step_plus;
              speed_next = plus_speed;
            end
            hsq_pkg::ACT_HOME: begin
              run_next    = 1'b0;
              finish_next = 1'b1;
              state_next  = hsq_pkg::HSQ_SETTLE;
            end
            default: begin
              run_next   = 1'b0;
              step_next  = step_plus;
              state_next = hsq_pkg::HSQ_SETTLE;
            end
          endcase
        end
      end
      default: begin
        run_next   = 1'b0;
        state_next = hsq_pkg::HSQ_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= hsq_pkg::HSQ_IDLE;
      step_reg      <= hsq_pkg::IDX_A_COLD;
      turn_used_reg <= 1'b0;
      finish_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      step_reg      <= step_next;
      turn_used_reg <= turn_used_next;
      finish_reg    <= finish_next;
    end
  end

  // motion demand registers toward the profiler
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg   <= 1'b0;
      fwd_reg   <= hsq_pkg::DIR_REV;
      speed_reg <= '0;
    end else begin
      run_reg   <= run_next;
      fwd_reg   <= fwd_next;
      speed_reg <= speed_next;
    end
  end

  // result registers; busy is a flop so it lines up with the state
  logic busy_reg;
  wire  busy_next = (state_next == hsq_pkg::HSQ_SETTLE) | (state_next == hsq_pkg::HSQ_MOVE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg     <= 1'b0;
      alarm_reg    <= 1'b0;
      home_pos_reg <= '0;
      busy_reg     <= 1'b0;
    end else begin
      done_reg     <= done_next;
      alarm_reg    <= alarm_next;
      home_pos_reg <= home_pos_next;
      busy_reg     <= busy_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign motion_run     = run_reg;
  assign motion_forward = fwd_reg;
  assign motion_speed   = speed_reg;
  assign homing_busy    = busy_reg;
  assign homing_done    = done_reg;
  assign homing_alarm   = alarm_reg;
  assign home_position  = home_pos_reg;

endmodule // hsq_homing_sequencer

// ==== test/hsq_homing_chk.sv ====
// concurrent port checks for the homing switch sequencer
module hsq_homing_chk #(
  parameter int SPEED_W = 16,
  parameter int POS_W   = 32
) (
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic               start,
  input wire logic [5:0]         method,
  input wire logic [SPEED_W-1:0] high_speed,
  input wire logic [SPEED_W-1:0] low_speed,
  input wire logic               home_switch,
  input wire logic               forward_limit_switch,
  input wire logic               reverse_limit_switch,
  input wire logic               motion_standstill,
  input wire logic [POS_W-1:0]   current_position,
  input wire logic               motion_run,
  input wire logic               motion_forward,
  input wire logic [SPEED_W-1:0] motion_speed,
  input wire logic               homing_busy,
  input wire logic               homing_done,
  input wire logic               homing_alarm,
  input wire logic [POS_W-1:0]   home_position
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // live decode is safe only because the host holds the method steady
  wire logic ok_m = method >= hsq_pkg::METHOD_19 && method <= hsq_pkg::METHOD_24;
  wire logic lvl_m = method <= hsq_pkg::METHOD_22;
  wire logic idle_go = start && !homing_busy;
  ////////////////////////////////////////////////////////////////////////
  start_take_a: assert property (idle_go && ok_m |=> homing_busy && !homing_done && !homing_alarm)
    else $error("valid start not taken");
  warm_slow_a: assert property (idle_go && ok_m && home_switch |-> ##2 motion_run && motion_speed == low_speed)
    else $error("warm start not at low speed");
  limit_abort_a: assert property (homing_busy && ok_m && lvl_m
    && (forward_limit_switch || reverse_limit_switch) |-> ##[1:3] homing_alarm)
    else $error("limit did not abort");
  rev_limit_a: assert property (homing_busy && !lvl_m && reverse_limit_switch |-> ##[1:3] homing_alarm)
    else $error("reverse limit did not abort");
  end_quiet_a: assert property ((homing_done || homing_alarm) |-> !motion_run && !homing_busy)
    else $error("motion after end of homing");
  flag_excl_a: assert property (!(homing_done && homing_alarm))
    else $error("done and alarm together");
  done_sticky_a: assert property (homing_done && !start |=> homing_done)
    else $error("done dropped without start");
  home_latch_a: assert property ($rose(homing_done) |-> home_position == $past(current_position))
    else $error("home not latched at final stop");
  run_rise_a: assert property ($rose(motion_run) |-> $past(motion_standstill)
    && (motion_speed == high_speed || motion_speed == low_speed)) else $error("bad move launch");
  slow_only_a: assert property (motion_run && $past(motion_run) && motion_speed != $past(motion_speed)
    |-> motion_speed == low_speed) else $error("speed change not to low");
endmodule // hsq_homing_chk

bind hsq_homing_sequencer hsq_homing_chk #(.SPEED_W(SPEED_W), .POS_W(POS_W)) i_hsq_homing_chk (
  .clk, .reset_n, .start, .method, .high_speed, .low_speed, .home_switch, .forward_limit_switch,
  .reverse_limit_switch, .motion_standstill, .current_position, .motion_run, .motion_forward,
  .motion_speed, .homing_busy, .homing_done, .homing_alarm, .home_position);

// ==== test/hsq_motor_model.sv ====
// behavioural motor, profiler and switch model for the homing bench
module hsq_motor_model #(
  parameter int SPEED_W = 16,
  parameter int POS_W   = 32
) (
  input  wire logic               clk,
  input  wire logic               motion_run,
  input  wire logic               motion_forward,
  input  wire logic [SPEED_W-1:0] motion_speed,
  input  wire logic               load,
  input  wire logic [POS_W-1:0]   load_pos,
  input  wire logic               switch_en,
  output logic                    home_switch,
  output logic                    forward_limit_switch,
  output logic                    reverse_limit_switch,
  output logic                    motion_standstill,
  output logic [POS_W-1:0]        current_position
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [POS_W-1:0] pos_reg = POS_W'(100);
  logic [1:0]       coast_reg = 2'h0;
  logic             dir_reg = 1'b0;
  logic             still_reg = 1'b1;
  // switches follow shaft position; a missing switch simply reads off
  assign home_switch = switch_en && pos_reg >= POS_W'(200) && pos_reg <= POS_W'(300);
  assign forward_limit_switch = pos_reg >= POS_W'(600);
  assign reverse_limit_switch = pos_reg <= POS_W'(20);
  assign motion_standstill = still_reg;
  assign current_position = pos_reg;
  ////////////////////////////////////////////////////////////////////////
  // shaft coasts three counts after run drops, so every stop overshoots
  always @(posedge clk) begin
    if (load) begin
      pos_reg <= load_pos;
      coast_reg <= 2'h0;
      still_reg <= 1'b1;
    end else if (motion_run) begin
      pos_reg <= motion_forward ? pos_reg + POS_W'(motion_speed) : pos_reg - POS_W'(motion_speed);
      dir_reg <= motion_forward;
      coast_reg <= 2'h3;
      still_reg <= 1'b0;
    end else if (coast_reg != 2'h0) begin
      pos_reg <= dir_reg ? pos_reg + POS_W'(1) : pos_reg - POS_W'(1);
      coast_reg <= coast_reg - 2'h1;
    end else begin
      still_reg <= 1'b1;
    end
  end
endmodule // hsq_motor_model

// ==== test/hsq_homing_sequencer_test.sv ====
// self-checking bench for the homing switch sequencer
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_fail++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module hsq_homing_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] RL = 3'h0, RH = 3'h1, FL = 3'h2, FH = 3'h3, SL = 3'h4;
  logic        clk = 1'b0, reset_n = 1'b0, start = 1'b0, load = 1'b0, switch_en = 1'b1;
  logic [5:0]  method = 6'h13;
  logic [15:0] high_speed = 16'h0004, low_speed = 16'h0001, spd_d = 16'h0000;
  logic [31:0] load_pos = 32'h0000_0064, lfsr = 32'h3651;
  logic        run_d = 1'b0;
  logic [2:0]  seq_q[$];
  int          n_fail = 0, n_compared = 0;
  wire logic   home_switch, forward_limit_switch, reverse_limit_switch, motion_standstill;
  wire logic   motion_run, motion_forward, homing_busy, homing_done, homing_alarm;
  wire logic [15:0] motion_speed;
  wire logic [31:0] current_position, home_position;

  hsq_homing_sequencer i_hsq_homing_sequencer (.clk, .reset_n, .start, .method, .high_speed,
    .low_speed, .home_switch, .forward_limit_switch, .reverse_limit_switch, .motion_standstill,
    .current_position, .motion_run, .motion_forward, .motion_speed, .homing_busy, .homing_done,
    .homing_alarm, .home_position);
  hsq_motor_model i_hsq_motor_model (.clk, .motion_run, .motion_forward, .motion_speed, .load,
    .load_pos, .switch_en, .home_switch, .forward_limit_switch, .reverse_limit_switch,
    .motion_standstill, .current_position);

  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  // move log: launch direction and speed, plus a mark when a run drops to low speed
  always @(negedge clk) begin
    if (motion_run && !run_d) seq_q.push_back({1'b0, motion_forward, motion_speed == high_speed});
    else if (motion_run && motion_speed != spd_d) seq_q.push_back(SL);
    run_d = motion_run;
    spd_d = motion_speed;
  end

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // home lies within 12 counts past the final edge, on the side the final move was heading toward
  function automatic logic in_win(input logic [31:0] p, input int e, input logic ef);
    return ef ? (p >= 32'(e) && p <= 32'(e + 12)) : (p <= 32'(e) && p + 32'h0000_000C >= 32'(e));
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // region 0 below the switch, 1 on it, 2 above it; high speed and start point drawn at random
  task automatic go(input logic [5:0] m, input int r, input logic sw, input int n,
                    input logic [14:0] c, input int e, input logic ef, input logic ab);
    int k;
    lfsr = nxt(lfsr);
    high_speed = 16'h0003 + 16'(lfsr[1:0]);
    load_pos = 32'(r == 0 ? 60 + lfsr[7:2] : r == 1 ? 220 + lfsr[5:2] * 3 : 350 + lfsr[8:2]);
    switch_en = sw;
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
    method = m;
    start = 1'b1;
    seq_q.delete();
    @(negedge clk);
    start = 1'b0;
    for (k = 0; k < 20000 && homing_busy !== 1'b0; k++) @(negedge clk);
    for (k = k; k < 20000 && motion_standstill !== 1'b1; k++) @(negedge clk);
    if (k >= 20000) begin
      n_fail++;
      give_verdict();
    end else begin
      `CHK("alarm", ab, homing_alarm)
      `CHK("done", !ab, homing_done)
      `CHK("move_count", n, seq_q.size())
      for (k = 0; k < n; k++) `CHK("move", c[3*(n-1-k) +: 3], seq_q[k])
      if (!ab) begin
        `CHK("home_at_rest", current_position, home_position)
        `CHK("home_window", 1'b1, in_win(home_position, e, ef))
      end
    end
  endtask

  initial begin
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    go(6'h19, 1, 1'b1, 0, 15'h0000, 0, 1'b0, 1'b1);
    repeat (3) begin
      go(hsq_pkg::METHOD_19, 0, 1'b1, 2, 15'({FH, RL}), 199, 1'b0, 1'b0);
      go(hsq_pkg::METHOD_19, 1, 1'b1, 1, 15'(RL), 199, 1'b0, 1'b0);
      go(hsq_pkg::METHOD_20, 0, 1'b1, 3, 15'({FH, RL, FL}), 200, 1'b1, 1'b0);
      go(hsq_pkg::METHOD_20, 1, 1'b1, 2, 15'({RL, FL}), 200, 1'b1, 1'b0);
      go(hsq_pkg::METHOD_21, 2, 1'b1, 2, 15'({RH, FL}), 301, 1'b1, 1'b0);
      go(hsq_pkg::METHOD_21, 1, 1'b1, 1, 15'(FL), 301, 1'b1, 1'b0);
      go(hsq_pkg::METHOD_22, 2, 1'b1, 3, 15'({RH, FL, RL}), 300, 1'b0, 1'b0);
      go(hsq_pkg::METHOD_22, 1, 1'b1, 2, 15'({FL, RL}), 300, 1'b0, 1'b0);
      go(hsq_pkg::METHOD_23, 2, 1'b1, 5, {FH, RH, SL, FL, RL}, 199, 1'b0, 1'b0);
      go(hsq_pkg::METHOD_23, 0, 1'b1, 2, 15'({FH, RL}), 199, 1'b0, 1'b0);
      go(hsq_pkg::METHOD_23, 1, 1'b1, 1, 15'(RL), 199, 1'b0, 1'b0);
      go(hsq_pkg::METHOD_24, 2, 1'b1, 4, 15'({FH, RH, SL, FL}), 200, 1'b1, 1'b0);
      go(hsq_pkg::METHOD_24, 0, 1'b1, 3, 15'({FH, RL, FL}), 200, 1'b1, 1'b0);
      go(hsq_pkg::METHOD_24, 1, 1'b1, 2, 15'({RL, FL}), 200, 1'b1, 1'b0);
      go(hsq_pkg::METHOD_19, 2, 1'b1, 1, 15'(FH), 0, 1'b0, 1'b1);
      go(hsq_pkg::METHOD_22, 0, 1'b1, 1, 15'(RH), 0, 1'b0, 1'b1);
      go(hsq_pkg::METHOD_23, 2, 1'b0, 2, 15'({FH, RH}), 0, 1'b0, 1'b1);
    end
    give_verdict();
  end
endmodule // hsq_homing_sequencer_test
